// File: shared/hacs_regs.svh
// Functional notes
// RULE1: Bit 16 reports memory expansion support.
// RULE2: Bit 17 reports the Evict sending preference.
// RULE3: Bit 18 reports the WriteEvictFull sending preference.
// RULE4: Bits 27:19 hold unsigned readiness count.
// RULE5: Count zero means pools always ready.
// RULE6: Bits 30:28 scale multiplier 32^scale ns.
// RULE7: Reported time covers both reset kinds.
// RULE8: Time fields valid from reset onward.
// RULE9: Agent may lower count, scale, or both.
// RULE10: Reported readiness time never increases.
// RULE11: Software may use original or reduced time.
// RULE12: All fields read-only; writes have no effect.
// RULE13: Pool ready flag set by reported time.
`ifndef HACS_REGS_SVH
`define HACS_REGS_SVH

`define HACS_MEM_EXPN_BIT 16
`define HACS_EVICT_HINT_BIT 17
`define HACS_FULL_WB_HINT_BIT 18
`define HACS_COUNT_LSB 19
`define HACS_COUNT_MSB 27
`define HACS_EXP_LSB 28
`define HACS_EXP_MSB 30
`define HACS_POOL_RDY_BIT 31
`define HACS_FIELDS_LSB 16
`define HACS_LOW_ZERO 16'h0000
`define HACS_COUNT_MAX 9'h01FF
`define HACS_COUNT_ZERO 9'h0000
`define HACS_EXP_MAX 3'h7
`define HACS_EXP_ZERO 3'h0
`define HACS_SCALE_SHIFT 5
`define HACS_TIME_W 48
`define HACS_CLK_MHZ 40
`define HACS_CLK_PERIOD_NS (1000 / `HACS_CLK_MHZ)
`define HACS_LEAD_CYCLES 2

`endif

// File: shared/hacs_pkg.sv
`include "hacs_regs.svh"

package hacs_pkg;

    typedef logic [`HACS_TIME_W-1:0] hacs_time_type;

    // Packed order matches bits 31 down to 16
    typedef struct packed {
        logic pool_ready;
        logic [2:0] exponent;
        logic [8:0] count;
        logic full_wb_hint;
        logic evict_hint;
        logic mem_expansion;
    } hacs_fields_type;

    function automatic hacs_time_type ready_time_ns(
        input logic [8:0] count,
        input logic [2:0] exponent
    );
        hacs_time_type t;
        t = hacs_time_type'(count) << (`HACS_SCALE_SHIFT * exponent);
        return t;
    endfunction : ready_time_ns

    // Smallest scale whose rounded-up count fits; saturates at maximum
    function automatic logic [11:0] encode_ready_time(input hacs_time_type ns);
        logic [11:0] code;
        hacs_time_type step;
        hacs_time_type q;
        code = {`HACS_EXP_MAX, `HACS_COUNT_MAX};
        for (int e = 7; e >= 0; e--) begin
            step = hacs_time_type'(1) << (`HACS_SCALE_SHIFT * e);
            q = (ns + step - hacs_time_type'(1)) >> (`HACS_SCALE_SHIFT * e);
            if (q <= hacs_time_type'(`HACS_COUNT_MAX)) begin
                code = {3'(e), q[8:0]};
            end
        end
        return code;
    endfunction : encode_ready_time

endpackage : hacs_pkg

// File: src/hacs_ready_timer.sv
`timescale 1ns/1ps
`include "hacs_regs.svh"

module hacs_ready_timer (
    input wire logic i_clk, // 40 MHz clock
    input wire logic i_rst_n, // Async reset, active low
    input wire hacs_pkg::hacs_time_type i_limit_ns, // Deadline in ns
    output logic o_expired // Deadline reached, sticky
);

    localparam hacs_pkg::hacs_time_type PERIOD_NS =
        hacs_pkg::hacs_time_type'(`HACS_CLK_PERIOD_NS);
    localparam hacs_pkg::hacs_time_type LEAD_NS =
        hacs_pkg::hacs_time_type'(`HACS_LEAD_CYCLES * `HACS_CLK_PERIOD_NS);
    localparam hacs_pkg::hacs_time_type TIME_TOP = '1;

    hacs_pkg::hacs_time_type elapsed_ff;
    logic expired_ff;

    // Saturates rather than wrapping back under the limit
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            elapsed_ff <= '0;
        end else if (elapsed_ff <= TIME_TOP - PERIOD_NS) begin
            elapsed_ff <= elapsed_ff + PERIOD_NS;
        end
    end

    // Lead covers the two register stages up to the flag
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            expired_ff <= 1'b0;
        end else if (elapsed_ff + LEAD_NS >= i_limit_ns) begin
            expired_ff <= 1'b1; // RULE13
        end
    end

    assign o_expired = expired_ff;

endmodule : hacs_ready_timer

// File: src/hacs_capability_status.sv
`timescale 1ns/1ps
`include "hacs_regs.svh"

module hacs_capability_status #(
    parameter logic MEM_EXPANSION_SUPPORTED = 1'b0,
    parameter logic EVICT_HINT = 1'b0,
    parameter logic FULL_WB_HINT = 1'b0,
    parameter logic [63:0] CONV_RESET_READY_NS = 64'h0000_0000_000F_4240,
    parameter logic [63:0] FLR_READY_NS = 64'h0000_0000_000F_4240
) (
    input wire logic i_clk, // 40 MHz clock
    input wire logic i_rst_n, // Async reset, active low
    input wire logic i_pools_ready, // Pools discovered by init logic
    input wire logic i_reduce_req, // Request lower readiness time
    input wire logic [8:0] i_reduce_count, // Requested count
    input wire logic [2:0] i_reduce_exponent, // Requested scale
    output logic [31:0] o_capability_status, // Register word, read-only
    output logic o_reduce_accepted // One-cycle reduce acknowledge
);

    localparam logic [63:0] WORST_NS =
        (CONV_RESET_READY_NS > FLR_READY_NS) ?
        CONV_RESET_READY_NS : FLR_READY_NS; // RULE7
    localparam logic [11:0] INIT_CODE =
        hacs_pkg::encode_ready_time(WORST_NS[`HACS_TIME_W-1:0]); // RULE7
    localparam logic [2:0] INIT_EXP = INIT_CODE[11:9];
    localparam logic [8:0] INIT_COUNT = INIT_CODE[8:0];

    hacs_pkg::hacs_fields_type fields_ff;
    logic reduce_accepted_ff;
    logic timer_expired;
    logic reduce_ok;
    hacs_pkg::hacs_time_type now_ns;
    hacs_pkg::hacs_time_type req_ns;

    assign now_ns = hacs_pkg::ready_time_ns(fields_ff.count,
                                            fields_ff.exponent); // RULE6
    assign req_ns = hacs_pkg::ready_time_ns(i_reduce_count,
                                            i_reduce_exponent);
    // Only during init, and never upward
    assign reduce_ok = i_reduce_req && !fields_ff.pool_ready &&
                       (req_ns <= now_ns); // RULE9 RULE10

    // Fixed capabilities; no write path exists at all
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fields_ff.mem_expansion <= MEM_EXPANSION_SUPPORTED; // RULE1
            fields_ff.evict_hint <= EVICT_HINT; // RULE2
            fields_ff.full_wb_hint <= FULL_WB_HINT; // RULE3
        end else begin
            fields_ff.mem_expansion <= fields_ff.mem_expansion; // RULE12
            fields_ff.evict_hint <= fields_ff.evict_hint; // RULE12
            fields_ff.full_wb_hint <= fields_ff.full_wb_hint; // RULE12
        end
    end

    // Encoded time holds a valid value from reset onward
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fields_ff.count <= INIT_COUNT; // RULE4 RULE8
            fields_ff.exponent <= INIT_EXP; // RULE6 RULE8
        end else if (reduce_ok) begin
            fields_ff.count <= i_reduce_count; // RULE9
            fields_ff.exponent <= i_reduce_exponent; // RULE9
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            reduce_accepted_ff <= 1'b0;
        end else begin
            reduce_accepted_ff <= reduce_ok;
        end
    end

    // Deadline follows the current, smallest reported time, so
    // software waiting on either figure sees the flag in time
    hacs_ready_timer u_timer (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_limit_ns(now_ns), // RULE11
        .o_expired(timer_expired)
    );

    // Sticky; forced at the deadline even if init lags
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fields_ff.pool_ready <= 1'b0;
        end else if (i_pools_ready || timer_expired) begin
            fields_ff.pool_ready <= 1'b1; // RULE13
        end else if (fields_ff.count == `HACS_COUNT_ZERO) begin
            fields_ff.pool_ready <= 1'b1; // RULE5
        end
    end

    assign o_capability_status = {fields_ff, `HACS_LOW_ZERO};
    assign o_reduce_accepted = reduce_accepted_ff;

endmodule : hacs_capability_status

// File: sim/hacs_capability_status_checker.sv
`timescale 1ns/1ps
module hacs_checker #(
    parameter logic MEM_EXPANSION_SUPPORTED = 1'b0,
    parameter logic EVICT_HINT = 1'b0,
    parameter logic FULL_WB_HINT = 1'b0
) (
    input wire logic i_clk, // Clock
    input wire logic i_rst_n, // Reset
    input wire logic i_pools_ready, // Pools found
    input wire logic i_reduce_req, // Reduce request
    input wire logic [8:0] i_reduce_count, // Count
    input wire logic [2:0] i_reduce_exponent, // Scale
    input wire logic [31:0] o_capability_status, // Word
    input wire logic o_reduce_accepted // Acknowledge
);
    logic [47:0] t;
    logic [47:0] el_ff;
    logic [31:0] w;
    assign w = o_capability_status;
    assign t = {39'h0, w[27:19]} << (5 * w[30:28]);
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            el_ff <= 48'h0;
        end else begin
            el_ff <= el_ff + 48'h19;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    cap_bits_a: assert property (w[18:16] == {FULL_WB_HINT,
        EVICT_HINT, MEM_EXPANSION_SUPPORTED}) else $error("capability bits");
    no_raise_a: assert property (t <= $past(t)) else $error("time rose");
    ack_fields_a: assert property (o_reduce_accepted |-> $past(i_reduce_req) &&
        w[30:19] == {$past(i_reduce_exponent), $past(i_reduce_count)})
        else $error("reduce fields");
    hold_fields_a: assert property (!o_reduce_accepted |->
        $stable(w[30:19])) else $error("fields moved");
    flag_hold_a: assert property (w[31] |=> w[31]) else $error("flag fell");
    pools_flag_a: assert property (i_pools_ready |=> w[31])
        else $error("pools flag");
    zero_ready_a: assert property (w[27:19] == 9'h0 |=> w[31])
        else $error("zero count flag");
    deadline_a: assert property (el_ff >= $past(t, 3) + 48'h32 |-> w[31])
        else $error("flag late");
endmodule : hacs_checker
bind hacs_capability_status hacs_checker #(
    .MEM_EXPANSION_SUPPORTED(MEM_EXPANSION_SUPPORTED),
    .EVICT_HINT(EVICT_HINT), .FULL_WB_HINT(FULL_WB_HINT)) u_chk (.i_clk,
    .i_rst_n, .i_pools_ready, .i_reduce_req, .i_reduce_count,
    .i_reduce_exponent, .o_capability_status, .o_reduce_accepted);

// File: sim/tb_home_agent_capability_status.sv
`timescale 1ns/1ps
module tb_home_agent_capability_status;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_pools_ready = 1'b0;
    logic i_reduce_req = 1'b0;
    logic [8:0] i_reduce_count = 9'h0;
    logic [2:0] i_reduce_exponent = 3'h0;
    logic [31:0] o_capability_status;
    logic o_reduce_accepted;
    int n_mismatch = 0;
    int checked = 0;
    logic [31:0] lf = 32'h4a4e_a59e;
    logic rdy;
    logic [8:0] ec;
    logic [2:0] ee;
    hacs_capability_status #(.MEM_EXPANSION_SUPPORTED(1'b1),
        .FULL_WB_HINT(1'b1), .CONV_RESET_READY_NS(64'h0001_86a0)) dut (
        .i_clk, .i_rst_n, .i_pools_ready, .i_reduce_req, .i_reduce_count,
        .i_reduce_exponent, .o_capability_status, .o_reduce_accepted);
    initial forever #12.5 i_clk = ~i_clk;
    // Worst deadline is about 41k cycles; cut off at 60k
    initial begin
        #1500000;
        n_mismatch++;
        final_report();
    end
    function automatic logic [47:0] tns(logic [8:0] c, logic [2:0] e);
        return {39'h0, c} << (5 * e);
    endfunction : tns
    function automatic logic [31:0] lfsr(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    function automatic logic [11:0] enc(logic [47:0] t);
        logic [47:0] q;
        for (int e = 0; e < 8; e++) begin
            q = (t + (48'h1 << 5 * e) - 48'h1) >> (5 * e);
            if (q < 48'h200) return {3'(e), q[8:0]};
        end
        return 12'hfff;
    endfunction : enc
    function automatic logic [31:0] ew();
        return {rdy, ee, ec, 19'h5_0000};
    endfunction : ew
    task automatic chk(string n, logic [31:0] x, logic [31:0] s);
        checked++;
        if (s !== x) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", n, x, s);
        end
    endtask : chk
    task automatic rst();
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        rdy = 1'b0;
        {ee, ec} = enc(48'h000f_4240); // Longer of the two reset times
        repeat (6) @(posedge i_clk);
        #1 chk("reset word", ew(), o_capability_status);
        @(posedge i_clk);
        i_rst_n <= 1'b1;
    endtask : rst
    task automatic req(logic [8:0] c, logic [2:0] e);
        logic a;
        @(posedge i_clk);
        i_reduce_req <= 1'b1;
        i_reduce_count <= c;
        i_reduce_exponent <= e;
        a = !rdy && tns(c, e) <= tns(ec, ee);
        @(posedge i_clk);
        i_reduce_req <= 1'b0;
        #1 chk("ack", {31'h0, a}, {31'h0, o_reduce_accepted});
        if (a) {ee, ec} = {e, c};
        chk("word", ew(), o_capability_status);
    endtask : req
    initial begin
        rst();
        chk("covers", 1, tns(ec, ee) >= 48'h000f_4240);
        req(9'h1ff, 3'h7);
        for (int k = 0; k < 12; k++) begin
            lf = lfsr(lf);
            req(lf[8:0] | 9'h100, {2'b01, lf[9]});
        end
        req(ec, ee);
        repeat (tns(ec, ee) / 25) @(posedge i_clk);
        #1 rdy = 1'b1;
        chk("deadline", ew(), o_capability_status);
        req(9'h0, 3'h0);
        $display("test deadline done");
        rst();
        @(posedge i_clk);
        i_pools_ready <= 1'b1;
        @(posedge i_clk);
        i_pools_ready <= 1'b0;
        #1 rdy = 1'b1;
        chk("pools", ew(), o_capability_status);
        $display("test pools done");
        rst();
        req(9'h0, 3'h4);
        repeat (2) @(posedge i_clk);
        #1 rdy = 1'b1;
        chk("zero", ew(), o_capability_status);
        $display("test zero done");
        final_report();
    end
    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
endmodule : tb_home_agent_capability_status
